// file: common/lec_pkg.sv
// Constants for the link enhancement control block: register map,
// field positions, reset values, transmit thresholds and state codes.
// Assumes a 32-bit APB register bus and 32-bit transmit FIFO words.
package lec_pkg;
    // Register byte offsets on the APB
    localparam logic [11:0] LEC_CTRL_OFS = 12'h000;
    localparam logic [11:0] LEC_RETRY_OFS = 12'h004;
    localparam logic [11:0] LEC_STAT_OFS = 12'h008;

    // Field positions in the control register
    localparam int LEC_REORDER_DIS_BIT = 15;
    localparam int LEC_THR_LO = 12;
    localparam int LEC_MPEG_BIT = 10;
    localparam int LEC_DV_BIT = 8;
    localparam int LEC_PRIO_BIT = 7;
    localparam int LEC_ACCEL_BIT = 1;

    // Control reset value (threshold field 01) and writable bits
    localparam logic [15:0] LEC_CTRL_RESET = 16'h1000;
    localparam logic [15:0] LEC_CTRL_WMASK = 16'hb582;

    // Retry register width and reset value
    localparam int LEC_RETRY_W = 4;
    localparam logic [3:0] LEC_RETRY_RESET = 4'h1;

    // Status register fields
    localparam int LEC_ST_UNDERRUN_BIT = 0;
    localparam int LEC_ST_RETRY_BIT = 1;
    localparam int LEC_ST_BUSY_BIT = 2;
    localparam int LEC_ST_FILL_LO = 4;

    // Threshold field codes
    localparam logic [1:0] LEC_THR_SAF = 2'h0;
    localparam logic [1:0] LEC_THR_LOW = 2'h3;

    // Thresholds in bytes and in 32-bit words
    localparam int LEC_THR_SAF_BYTES = 2048;
    localparam int LEC_THR_MID_BYTES = 1700;
    localparam int LEC_THR_LOW_BYTES = 512;
    localparam logic [9:0] LEC_THR_SAF_WORDS = 10'(LEC_THR_SAF_BYTES / 4);
    localparam logic [9:0] LEC_THR_MID_WORDS = 10'(LEC_THR_MID_BYTES / 4);
    localparam logic [9:0] LEC_THR_LOW_WORDS = 10'(LEC_THR_LOW_BYTES / 4);

    // CIP format codes that take the timestamp enhancement
    localparam logic [5:0] LEC_FMT_MPEG = 6'h20;
    localparam logic [5:0] LEC_FMT_DV = 6'h00;

    // Transmit engine states
    typedef enum logic [1:0] {LEC_IDLE, LEC_WAIT, LEC_SEND} lec_tx_state_t;
endpackage : lec_pkg

// file: common/lec_stream_if.sv
// Valid/ready word stream between the transmit engine and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface lec_stream_if #(parameter int W = 34);
    logic valid; // Word offered
    logic ready; // Word taken when both high
    logic [W-1:0] data; // Word content
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : lec_stream_if

// file: core/lec_buf2.sv
// Two-entry buffer on the transmit path; outputs come from flip-flops.
// Assumes the sink may stall at any time; ready on the fill side drops when full.
`timescale 1ns/1ps
module lec_buf2 #(parameter int W = 34) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_flush,
    // Streams
    lec_stream_if.snk s_in,
    lec_stream_if.src s_out
);
    logic [W-1:0] e0_reg; // Head entry
    logic [W-1:0] e1_reg; // Second entry
    logic [1:0] cnt_reg; // Entries held
    logic vld_reg; // Head valid, its own flop so the output is registered
    wire push = s_in.valid & s_in.ready;
    wire pop = s_out.valid & s_out.ready;
    wire [1:0] cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop}; // Count after this edge

    assign s_in.ready = (cnt_reg != 2'h2);
    assign s_out.valid = vld_reg;
    assign s_out.data = e0_reg;

    // Occupancy count and registered valid
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 2'h0;
            vld_reg <= 1'b0;
        end else if (i_flush) begin
            cnt_reg <= 2'h0;
            vld_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            vld_reg <= (cnt_next != 2'h0);
        end
    end

    // Entry shifting
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            e0_reg <= '0;
            e1_reg <= '0;
        end else begin
            if (pop && cnt_reg == 2'h2) e0_reg <= e1_reg;
            else if (push && (cnt_reg == 2'h0 || pop)) e0_reg <= s_in.data;
            if (push && cnt_reg == 2'h1 && !pop) e1_reg <= s_in.data;
        end
    end

    // Full buffer never takes a word
    a_buf_no_over: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cnt_reg == 2'h2 && !pop && !i_flush |=> cnt_reg == 2'h2)
        else $error("buffer count changed while full and stalled");
endmodule : lec_buf2

// file: core/lec_thr_dec.sv
// Decodes the threshold field into a start level in FIFO words.
// Assumes the caller samples the field once per packet.
`timescale 1ns/1ps
module lec_thr_dec
    import lec_pkg::*;
(
    // Field and override
    input wire logic [1:0] i_code,
    input wire logic i_force_saf,
    // Decoded level
    output logic [9:0] o_words,
    output logic o_saf
);
    wire code_saf = (i_code == LEC_THR_SAF);
    wire code_low = (i_code == LEC_THR_LOW);
    assign o_saf = code_saf | i_force_saf;
    assign o_words = o_saf ? LEC_THR_SAF_WORDS : (code_low ? LEC_THR_LOW_WORDS : LEC_THR_MID_WORDS);
endmodule : lec_thr_dec

// file: core/lec_top.sv
// Link enhancement control: register bank and asynchronous transmit FIFO.
// Assumes an APB master, a packet loader and a PHY-side word sink.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module lec_top
    import lec_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    // Clock and global reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_soft_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Packet loader
    input wire logic i_load_valid,
    input wire logic [31:0] i_load_data,
    input wire logic i_load_last,
    output logic o_load_ready,
    // PHY transmit stream
    output logic o_tx_valid,
    output logic [31:0] o_tx_data,
    output logic o_tx_last,
    output logic o_tx_err,
    input wire logic i_tx_ready,
    // Isochronous stream format
    input wire logic [5:0] i_iso_fmt,
    // Enable outputs
    output logic o_async_tx_reorder_disable,
    output logic o_mpeg_stamp_enhance_en,
    output logic o_dv_stamp_enhance_en,
    output logic o_stamp_apply,
    output logic o_priority_req_en,
    output logic o_phy_accel_en
);
    localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);

    // Registers
    logic [15:0] ctl_reg; // Link enhancement control
    logic [LEC_RETRY_W-1:0] retry_reg; // Transmit retries limit
    logic underrun_reg; // Sticky underrun flag
    logic retry_mode_reg; // Packet is being retried
    logic pready_reg; // APB answer
    logic [31:0] prdata_reg; // APB read data
    logic pslverr_reg; // APB error
    logic stamp_reg; // Timestamp enhancement applies
    // FIFO and transmit engine
    logic [31:0] mem [DEPTH]; // Packet storage
    logic [AW:0] wr_ptr_reg; // Words loaded
    logic [AW:0] rd_ptr_reg; // Words sent
    logic last_in_reg; // End-of-packet token loaded
    logic [1:0] thr_code_reg; // Threshold code of this packet
    logic load_ready_reg; // Registered load ready
    lec_tx_state_t state_reg; // Engine state
    lec_tx_state_t state_next;

    // Stream to the buffer and from it
    lec_stream_if #(.W(34)) tx_in ();
    lec_stream_if #(.W(34)) tx_out ();

    // Address decode
    wire sel_ctrl = (i_paddr[11:2] == LEC_CTRL_OFS[11:2]);
    wire sel_retry = (i_paddr[11:2] == LEC_RETRY_OFS[11:2]);
    wire sel_stat = (i_paddr[11:2] == LEC_STAT_OFS[11:2]);
    wire mapped = sel_ctrl | sel_retry | sel_stat;
    wire acc = i_psel & i_penable & pready_reg;
    wire wr_en = acc & i_pwrite & mapped;
    wire ctrl_wr = wr_en & sel_ctrl;
    wire retry_wr = wr_en & sel_retry;
    wire stat_wr = wr_en & sel_stat;

    // Read data selection; masked bits read zero
    wire [31:0] rd_ctrl = {16'h0000, ctl_reg & LEC_CTRL_WMASK};
    wire [31:0] rd_retry = {{(32 - LEC_RETRY_W){1'b0}}, retry_reg};
    wire [31:0] rd_stat = {{(32 - LEC_ST_FILL_LO - AW - 1){1'b0}}, wr_ptr_reg, 1'b0,
        (state_reg != LEC_IDLE), retry_mode_reg, underrun_reg};
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl : (sel_retry ? rd_retry : (sel_stat ? rd_stat : 32'h0000_0000));

    // Threshold for this packet; retry or zero retries force 2K
    wire force_saf = retry_mode_reg | (retry_reg == '0);
    logic [9:0] thr_words;
    logic thr_saf;
    lec_thr_dec u_dec (
        .i_code(thr_code_reg),
        .i_force_saf(force_saf),
        .o_words(thr_words),
        .o_saf(thr_saf)
    );

    // Load side
    wire load_acc = i_load_valid & load_ready_reg;
    wire [AW:0] wr_ptr_next = wr_ptr_reg + (AW + 1)'(load_acc);
    wire last_in_next = last_in_reg | (load_acc & i_load_last);
    wire pkt_start = load_acc & (wr_ptr_reg == '0);

    // Start decision: full packet, or threshold reached when not store-and-forward
    wire at_thr = (32'(wr_ptr_reg) >= 32'(thr_words));
    wire go = last_in_reg | (~thr_saf & at_thr);

    // Transmit side
    wire have_word = (rd_ptr_reg != wr_ptr_reg);
    wire underrun = (state_reg == LEC_SEND) & ~have_word & ~last_in_reg;
    wire is_last = last_in_reg & (rd_ptr_reg + 1'b1 == wr_ptr_reg);
    wire push = (state_reg == LEC_SEND) & tx_in.ready & (have_word | underrun);
    wire done = push & have_word & is_last;
    assign tx_in.valid = (state_reg == LEC_SEND) & (have_word | underrun);
    assign tx_in.data = underrun ? {1'b1, 1'b1, 32'h0000_0000} : {1'b0, is_last, mem[rd_ptr_reg[AW-1:0]]};
    assign tx_out.ready = i_tx_ready;

    // Buffer between FIFO and PHY
    lec_buf2 #(.W(34)) u_buf (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_flush(i_soft_rst),
        .s_in(tx_in),
        .s_out(tx_out)
    );

    // Engine next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LEC_IDLE: begin
                if (load_acc) state_next = LEC_WAIT;
            end
            LEC_WAIT: begin
                if (go) state_next = LEC_SEND;
            end
            LEC_SEND: begin
                if (push && underrun) state_next = LEC_WAIT;
                else if (done) state_next = LEC_IDLE;
            end
            default: state_next = LEC_IDLE;
        endcase
    end

    // Control register: loaded with its reset value only by the global reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) ctl_reg <= LEC_CTRL_RESET;
        else if (ctrl_wr) ctl_reg <= i_pwdata[15:0] & LEC_CTRL_WMASK;
    end

    // Retries register
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) retry_reg <= LEC_RETRY_RESET;
        else if (retry_wr) retry_reg <= i_pwdata[LEC_RETRY_W-1:0];
    end

    // Sticky underrun flag, write one to clear, set wins
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) underrun_reg <= 1'b0;
        else if (i_soft_rst) underrun_reg <= 1'b0;
        else if (push && underrun) underrun_reg <= 1'b1;
        else if (stat_wr && i_pwdata[LEC_ST_UNDERRUN_BIT]) underrun_reg <= 1'b0;
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= i_psel & i_penable & ~pready_reg;
            prdata_reg <= (i_psel & i_penable & ~pready_reg & ~i_pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_reg <= i_psel & i_penable & ~pready_reg & ~mapped;
        end
    end

    // FIFO write
    always_ff @(posedge i_ref_clk) begin
        if (load_acc) mem[wr_ptr_reg[AW-1:0]] <= i_load_data;
    end

    // Load pointer, token and threshold sample
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr_reg <= '0;
            last_in_reg <= 1'b0;
            thr_code_reg <= LEC_CTRL_RESET[LEC_THR_LO+1:LEC_THR_LO];
            load_ready_reg <= 1'b0;
        end else if (i_soft_rst || done) begin
            wr_ptr_reg <= '0;
            last_in_reg <= 1'b0;
            load_ready_reg <= ~i_soft_rst;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            last_in_reg <= last_in_next;
            if (pkt_start) thr_code_reg <= ctl_reg[LEC_THR_LO+1:LEC_THR_LO];
            // Count already includes this edge, so a full DEPTH-word packet fits
            load_ready_reg <= ~last_in_next & (wr_ptr_next < DEPTH_W);
        end
    end

    // Read pointer, state and retry mode
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_ptr_reg <= '0;
            state_reg <= LEC_IDLE;
            retry_mode_reg <= 1'b0;
        end else if (i_soft_rst) begin
            rd_ptr_reg <= '0;
            state_reg <= LEC_IDLE;
            retry_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (push && underrun) begin
                rd_ptr_reg <= '0;
                retry_mode_reg <= 1'b1;
            end else if (done) begin
                rd_ptr_reg <= '0;
                retry_mode_reg <= 1'b0;
            end else if (push) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // Timestamp enhancement per stream format
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) stamp_reg <= 1'b0;
        else stamp_reg <= (ctl_reg[LEC_MPEG_BIT] & (i_iso_fmt == LEC_FMT_MPEG))
            | (ctl_reg[LEC_DV_BIT] & (i_iso_fmt == LEC_FMT_DV));
    end

    // Outputs
    assign o_pready = pready_reg;
    assign o_prdata = prdata_reg;
    assign o_pslverr = pslverr_reg;
    assign o_load_ready = load_ready_reg;
    assign o_tx_valid = tx_out.valid;
    assign o_tx_err = tx_out.data[33];
    assign o_tx_last = tx_out.data[32];
    assign o_tx_data = tx_out.data[31:0];
    assign o_async_tx_reorder_disable = ctl_reg[LEC_REORDER_DIS_BIT];
    assign o_mpeg_stamp_enhance_en = ctl_reg[LEC_MPEG_BIT];
    assign o_dv_stamp_enhance_en = ctl_reg[LEC_DV_BIT];
    assign o_stamp_apply = stamp_reg;
    assign o_priority_req_en = ctl_reg[LEC_PRIO_BIT];
    assign o_phy_accel_en = ctl_reg[LEC_ACCEL_BIT];

    // Reserved control bits always read zero
    a_rsvd_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_psel && i_penable && !pready_reg && !i_pwrite && sel_ctrl
        |=> o_pready && o_prdata[31:16] == 16'h0000 && o_prdata[14] == 1'b0 && o_prdata[11] == 1'b0
            && o_prdata[9] == 1'b0 && o_prdata[6:2] == 5'h00 && o_prdata[0] == 1'b0)
        else $error("reserved control bit read as one");

    // Low code gives 128 words unless forced
    a_thr_low_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        thr_code_reg == 2'h3 && !force_saf |-> thr_words == 10'h080 && !thr_saf)
        else $error("low threshold code decoded wrongly");

    // Store-and-forward never starts before the token
    a_saf_waits_eop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_reg == LEC_WAIT && thr_saf && !last_in_reg && !i_soft_rst |=> state_reg != LEC_SEND)
        else $error("store-and-forward started before end of packet");

    // Reaching the threshold starts the send
    a_thr_starts: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_reg == LEC_WAIT && !thr_saf && at_thr && !i_soft_rst |=> state_reg == LEC_SEND)
        else $error("threshold reached but send did not start");

    // Underrun marks an error and retries in store-and-forward
    a_underrun_retry: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        push && underrun && !i_soft_rst |=> retry_mode_reg && thr_saf && state_reg == LEC_WAIT
            && rd_ptr_reg == '0 ##1 underrun_reg)
        else $error("underrun did not lead to a store-and-forward retry");

    // Zero retries forces store-and-forward
    a_retries_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        retry_reg == '0 |-> thr_saf && thr_words == LEC_THR_SAF_WORDS)
        else $error("zero retries did not force store-and-forward");

    // Formats pick their enable
    a_mpeg_apply: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_iso_fmt == 6'h20 |=> o_stamp_apply == $past(ctl_reg[LEC_MPEG_BIT]))
        else $error("MPEG stamp enhancement not applied");
    a_dv_apply: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_iso_fmt == 6'h00 |=> o_stamp_apply == $past(ctl_reg[LEC_DV_BIT]))
        else $error("DV stamp enhancement not applied");

    // Soft reset leaves control alone
    a_ctrl_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_soft_rst && !ctrl_wr |=> $stable(ctl_reg))
        else $error("control changed on soft reset");

    // Mid-packet change of the field waits for the next packet
    a_thr_sampled: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_reg == LEC_SEND && !pkt_start |=> $stable(thr_code_reg))
        else $error("threshold changed mid packet");

    // APB answers in the second access cycle
    a_apb_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_psel && i_penable && !pready_reg |=> o_pready ##1 !o_pready)
        else $error("APB answer timing wrong");
endmodule : lec_top

// file: bench/lec_phy_sink.sv
// PHY-side word sink model: drives the transmit ready line.
// Assumes the bench seeds $urandom and checks words in its own monitor.
`timescale 1ns/1ps
module lec_phy_sink (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Mode and ready
    input wire logic i_slow,
    output logic o_tx_ready
);
    // Ready every cycle, dropped at random in slow mode
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= !i_slow || ($urandom % 4 != 0);
        end
    end
endmodule : lec_phy_sink

// file: bench/testbench.sv
// Self-checking bench for lec_top: register map, enables, stamp gating,
// transmit thresholds, store-and-forward and underrun retry.
// Assumes lec_phy_sink as the PHY-side partner.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    import lec_pkg::*;
    // Design inputs and outputs
    logic i_ref_clk, i_rstn, i_soft_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, i_load_data, o_tx_data;
    logic i_load_valid, i_load_last, o_load_ready, o_tx_valid, o_tx_last, o_tx_err, i_tx_ready;
    logic [5:0] i_iso_fmt;
    logic o_stamp_apply, slow;
    wire [4:0] en_out; // Enables of bits 15, 10, 8, 7, 1
    // Bookkeeping
    int fail_count, n_tests, cyc;
    logic [33:0] tx_q[$]; // Expected err, last, data
    logic [64:0] apb_q[$]; // Expected error, mask, data
    logic [31:0] pkt[$]; // Current packet
    logic [33:0] exp_t;
    logic [64:0] exp_a;

    lec_top u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_soft_rst(i_soft_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
        .i_load_valid(i_load_valid), .i_load_data(i_load_data), .i_load_last(i_load_last),
        .o_load_ready(o_load_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
        .o_tx_last(o_tx_last), .o_tx_err(o_tx_err), .i_tx_ready(i_tx_ready), .i_iso_fmt(i_iso_fmt),
        .o_async_tx_reorder_disable(en_out[4]), .o_mpeg_stamp_enhance_en(en_out[3]),
        .o_dv_stamp_enhance_en(en_out[2]), .o_stamp_apply(o_stamp_apply),
        .o_priority_req_en(en_out[1]), .o_phy_accel_en(en_out[0]));
    lec_phy_sink u_sink (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_slow(slow), .o_tx_ready(i_tx_ready));

    // Clock
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            finish_test();
        end
    end

    // APB answers against the oldest note
    always @(posedge i_ref_clk) begin
        if (o_pready === 1'b1) begin
            exp_a = apb_q.pop_front();
            `CHK(o_pslverr, exp_a[64])
            `CHK(o_prdata & exp_a[63:32], exp_a[31:0])
        end
    end

    // Transmitted words against the oldest note
    always @(posedge i_ref_clk) begin
        if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
            exp_t = tx_q.pop_front();
            `CHK({o_tx_err, o_tx_last, o_tx_data}, exp_t)
        end
    end

    // One APB transfer; its expected error and masked read data are noted
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic [31:0] e, input logic er);
        apb_q.push_back({er, m, e});
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
        end while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // Feed packet words lo..hi-1, token on the final one when asked
    task automatic load(input int lo, input int hi, input bit tok);
        @(posedge i_ref_clk);
        for (int i = lo; i < hi; i++) begin
            i_load_valid <= 1'b1;
            i_load_data <= pkt[i];
            i_load_last <= tok && (i == hi - 1);
            do begin
                @(posedge i_ref_clk);
            end while (o_load_ready !== 1'b1);
        end
        i_load_valid <= 1'b0;
        i_load_last <= 1'b0;
    endtask : load

    // Packet with a pause after h words; st says sending starts in the pause
    task automatic run(input logic [1:0] c, input int h, input int n, input bit st, input logic [1:0] c2);
        pkt.delete();
        for (int i = 0; i < n; i++) begin
            pkt.push_back($urandom);
        end
        apb(1'b1, LEC_CTRL_OFS, 32'(c) << 12, 32'h0, 32'h0, 1'b0);
        if (st) begin
            for (int i = 0; i < h; i++) begin
                tx_q.push_back({2'b00, pkt[i]});
            end
            tx_q.push_back(34'h3_0000_0000);
        end
        for (int i = 0; i < n; i++) begin
            tx_q.push_back({1'b0, i == n - 1, pkt[i]});
        end
        load(0, h, 1'b0);
        apb(1'b1, LEC_CTRL_OFS, 32'(c2) << 12, 32'h0, 32'h0, 1'b0);
        while (tx_q.size() > n) begin
            @(posedge i_ref_clk);
        end
        repeat (12) @(posedge i_ref_clk);
        `CHK(o_tx_valid, 1'b0)
        if (st) begin
            apb(1'b0, LEC_STAT_OFS, 32'h0, 32'h3, 32'h3, 1'b0);
        end
        load(h, n, 1'b1);
        while (tx_q.size() > 0) begin
            @(posedge i_ref_clk);
        end
        apb(1'b1, LEC_STAT_OFS, 32'h1, 32'h0, 32'h0, 1'b0);
        apb(1'b0, LEC_STAT_OFS, 32'h0, 32'h1, 32'h0, 1'b0);
    endtask : run

    // Main sequence
    initial begin
        logic [5:0] f;
        void'($urandom(32'h1902637c));
        {i_rstn, i_soft_rst, i_psel, i_penable, i_pwrite, i_load_valid, i_load_last} = '0;
        {i_paddr, i_pwdata, i_load_data, i_iso_fmt} = '0;
        slow = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        apb(1'b0, LEC_CTRL_OFS, 32'h0, 32'hffffffff, 32'h1000, 1'b0);
        apb(1'b0, LEC_RETRY_OFS, 32'h0, 32'hffffffff, 32'h1, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, LEC_CTRL_OFS, 32'hffffbfff, 32'h0, 32'h0, 1'b0);
        apb(1'b0, LEC_CTRL_OFS, 32'h0, 32'hffffffff, 32'hb582, 1'b0);
        `CHK(en_out, 5'h1f)
        i_soft_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_soft_rst <= 1'b0;
        apb(1'b0, LEC_CTRL_OFS, 32'h0, 32'hffffffff, 32'hb582, 1'b0);
        `CHK(en_out, 5'h1f)
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        apb(1'b0, LEC_CTRL_OFS, 32'h0, 32'hffffffff, 32'h1000, 1'b0);
        for (int j = 0; j < 12; j++) begin
            f = (j < 4) ? 6'h20 : (j < 8) ? 6'h00 : 6'($urandom_range(1, 31));
            apb(1'b1, LEC_CTRL_OFS, (32'(j[0]) << 10) | (32'(j[1]) << 8) | (32'(j[2]) << 7), 32'h0, 32'h0, 1'b0);
            i_iso_fmt <= f;
            repeat (3) @(posedge i_ref_clk);
            `CHK(o_stamp_apply, (j[0] && f == 6'h20) || (j[1] && f == 6'h00))
            `CHK(en_out, {1'b0, j[0], j[1], j[2], 1'b0})
        end
        run(2'h0, 8, 9, 1'b0, 2'h0);
        run(2'h0, 511, 512, 1'b0, 2'h0);
        run(2'h0, 200, 210, 1'b0, 2'h3);
        slow <= 1'b0;
        run(2'h3, 127, 130, 1'b0, 2'h3);
        run(2'h3, 8, 9, 1'b0, 2'h3);
        slow <= 1'b1;
        run(2'h3, 128, 140, 1'b1, 2'h3);
        run(2'h2, 424, 430, 1'b0, 2'h2);
        run(2'h1, 425, 440, 1'b1, 2'h1);
        apb(1'b1, LEC_RETRY_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
        run(2'h3, 200, 210, 1'b0, 2'h3);
        repeat (2) @(posedge i_ref_clk);
        finish_test();
    end
endmodule : testbench
